// ===== rtl/adc_shift_in.v
// Serial ADC receiver: one 18-bit shift register per data line.
// Assumes serial clock, frame and data arrive asynchronously on pins.
`timescale 1ns/1ps
`include "current_loop_regs.vh"
module adc_shift_in (
   input  wire        mclk,
   input  wire        rstS_n,
   input  wire        adcSclk,
   input  wire        adcFrame,
   input  wire        adcData,
   output reg  [23:0] adcWord
);
   reg [2:0]  sclkSync;                   // Serial clock synchroniser plus edge stage
   reg [1:0]  frameSync;                  // Frame synchroniser
   reg [1:0]  dataSync;                   // Data synchroniser
   reg        frameLast;                  // Frame level of previous cycle
   reg [17:0] shiftReg;                   // Incoming bits

   // Two flops on every pin before use
   always @(posedge mclk or negedge rstS_n) begin
      if (!rstS_n) begin
         sclkSync  <= 3'h0;
         frameSync <= 2'h0;
         dataSync  <= 2'h0;
      end else begin
         sclkSync  <= {sclkSync[1:0], adcSclk};
         frameSync <= {frameSync[0], adcFrame};
         dataSync  <= {dataSync[0], adcData};
      end
   end

   // Shift on serial clock rise, publish at frame end
   always @(posedge mclk or negedge rstS_n) begin
      if (!rstS_n) begin
         shiftReg  <= 18'h00000;
         frameLast <= 1'b0;
         adcWord   <= 24'h000000;
      end else begin
         frameLast <= frameSync[1];
         if (frameSync[1] && sclkSync[1] && !sclkSync[2]) begin
            shiftReg <= {shiftReg[16:0], dataSync[1]};
         end
         if (frameLast && !frameSync[1]) begin
            // Left-justified into the high end of the word
            adcWord <= {shiftReg, {(`ADC_WORD_BITS-`ADC_SHIFT_BITS){1'b0}}};
         end
      end
   end
endmodule // adc_shift_in

// ===== rtl/current_loop_feedback_select.v
// Per-motor feedback select, mask and PI current loop with AXI4-Lite registers.
// Assumes a same-clock memory port whose read data is valid one cycle after memRead.
`timescale 1ns/1ps
`include "current_loop_regs.vh"
module current_loop_feedback_select #(
   parameter        ADC_CHANNEL = 1,          // Local ADC pair number
   parameter        RING_MODE   = 0,          // Nonzero selects ring node defaults
   parameter [11:0] PHASE_DIV   = `PHASE_DIV  // Cycles per phase interrupt
) (
   input  wire        mclk,
   input  wire        rst_n,
   // AXI4-Lite slave
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Serial ADC pins
   input  wire        adcSclk,
   input  wire        adcFrame,
   input  wire        adcDataA,
   input  wire        adcDataB,
   // Controller memory port
   output reg  [15:0] memAddr,
   output reg         memSpaceY,
   output reg         memRead,
   output reg         memWrite,
   output reg  [23:0] memWrData,
   input  wire [23:0] memRdData,
   // Phase interrupt marker
   output reg         phaseTick
);
   // One-hot sequencer states
   localparam [5:0] ST_IDLE = 6'h01;
   localparam [5:0] ST_POS  = 6'h02;
   localparam [5:0] ST_FBA  = 6'h04;
   localparam [5:0] ST_FBB  = 6'h08;
   localparam [5:0] ST_CALC = 6'h10;
   localparam [5:0] ST_WR   = 6'h20;

   // Local ADC pair address for this channel
   localparam integer LOCAL_ADC_FULL = `ADC_PAIR_BASE + `ADC_PAIR_STEP * (ADC_CHANNEL - 1);
   localparam [15:0] LOCAL_ADC = LOCAL_ADC_FULL[15:0];   // Cut to the 16-bit address on purpose
   localparam [23:0] POS_RESET = (RING_MODE != 0) ? `RST_POS_RING : `RST_POS_ADDR;

   reg  [1:0]  rstSync;                   // Reset release chain
   wire        rstS_n;                    // Synchronised reset

   // Software registers
   reg  [23:0] fbAddr;                    // Current feedback address
   reg  [23:0] posAddr;                   // Phase position address
   reg  [23:0] fbMask;                    // Current feedback mask
   reg         commEnable;                // Commutation enable setting
   reg  [23:0] cmdOutAddr;                // Command output address
   reg  [23:0] kiGain;                    // Loop integral gain
   reg  [23:0] kpFwd;                     // Forward proportional gain
   reg  [23:0] kpBack;                    // Back proportional gain
   reg  [23:0] pwmScale;                  // PWM scale factor
   reg  [23:0] phaseAngle;                // Commutation phase angle
   reg  [23:0] torqueCmd;                 // Servo torque command

   // Sequencer state
   reg  [5:0]  state;                     // One-hot state
   reg         waitData;                  // Read data arrives next cycle
   reg  [23:0] posWord;                   // Last commutation position
   reg  [23:0] fbRaw [0:1];               // Raw feedback words
   reg  [23:0] wrData [0:2];              // Words to write
   reg  [1:0]  wrIdx;                     // Write index
   reg  [1:0]  wrTotal;                   // Number of writes
   reg  [11:0] divCount;                  // Phase divider
   reg  [23:0] integ [0:1];               // Integrator per phase

   // AXI write holding
   reg  [7:0]  awAddrHold;                // Latched write address
   reg  [31:0] wDataHold;                 // Latched write data
   reg         awHave;                    // Address taken
   reg         wHave;                     // Data taken

   wire [23:0] adcWord [0:1];             // Local ADC words
   wire        loopOn;                    // Current loop active
   wire        localHit;                  // Feedback from local ADC pair
   wire [23:0] elecAngle;                 // Position plus phase angle
   wire signed [23:0] cmdPh [0:1];        // Phase current commands
   wire signed [23:0] vOut [0:1];         // PI voltage outputs
   wire signed [23:0] nextInteg [0:1];    // Integrator next values
   wire signed [24:0] vSum;               // Sum of first two voltages
   wire signed [23:0] vThird;             // Third voltage

   // Clamp a wide signed value to the 24-bit command range
   function [23:0] sat24;
      input signed [49:0] x;
      begin
         if (x > 50'sh00000007FFFFF) begin
            sat24 = 24'h7FFFFF;
         end else if (x < -50'sh00000000800000) begin
            sat24 = 24'h800000;
         end else begin
            sat24 = x[23:0];
         end
      end
   endfunction

   // Reset released through two flops
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rstSync <= 2'h0;
      end else begin
         rstSync <= {rstSync[0], 1'b1};
      end
   end
   assign rstS_n = rstSync[1];

   // Two serial receivers, one per phase current
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : gAdc
         adc_shift_in uAdc (
            .mclk     (mclk),
            .rstS_n   (rstS_n),
            .adcSclk  (adcSclk),
            .adcFrame (adcFrame),
            .adcData  ((g == 0) ? adcDataA : adcDataB),
            .adcWord  (adcWord[g])
         );
      end
   endgenerate

   assign loopOn    = (fbAddr != `RST_ZERO) && commEnable;
   assign localHit  = (fbAddr[15:0] == LOCAL_ADC);
   assign elecAngle = posWord + phaseAngle;
   // Square-wave commutation of the torque command into two phases
   assign cmdPh[0]  = elecAngle[23] ? -torqueCmd : torqueCmd;
   assign cmdPh[1]  = (elecAngle[23] ^ elecAngle[22]) ? -torqueCmd : torqueCmd;

   // PI filter per phase
   generate
      for (g = 0; g < 2; g = g + 1) begin : gPi
         wire signed [23:0] fbMasked = fbRaw[g] & fbMask;
         wire signed [24:0] err      = cmdPh[g] - fbMasked;
         wire signed [49:0] iTerm    = (err * $signed(kiGain)) >>> 23;
         wire signed [49:0] pFwd     = (err * $signed(kpFwd)) >>> 23;
         wire signed [49:0] pBack    = (fbMasked * $signed(kpBack)) >>> 23;
         wire signed [49:0] iSum     = $signed(integ[g]) + iTerm;
         wire signed [49:0] piSum    = $signed(nextInteg[g]) + pFwd - pBack;
         wire signed [23:0] piSat    = sat24(piSum);
         wire signed [49:0] scaled   = (piSat * $signed(pwmScale)) >>> 23;
         assign nextInteg[g] = sat24(iSum);
         assign vOut[g]      = sat24(scaled);

         // Integrator advances once per phase interrupt
         always @(posedge mclk or negedge rstS_n) begin
            if (!rstS_n) begin
               integ[g] <= `RST_ZERO;
            end else if (!loopOn) begin
               integ[g] <= `RST_ZERO;
            end else if (state == ST_CALC) begin
               integ[g] <= nextInteg[g];
            end
         end
      end
   endgenerate

   assign vSum   = vOut[0] + vOut[1];
   assign vThird = sat24(-{{25{vSum[24]}}, vSum});

   // Phase interrupt divider
   always @(posedge mclk or negedge rstS_n) begin
      if (!rstS_n) begin
         divCount  <= 12'h000;
         phaseTick <= 1'b0;
      end else begin
         phaseTick <= (divCount == PHASE_DIV - 12'h001);
         if (divCount == PHASE_DIV - 12'h001) begin
            divCount <= 12'h000;
         end else begin
            divCount <= divCount + 12'h001;
         end
      end
   end

   // Phase sequencer: position read, feedback read, PI, command writes
   always @(posedge mclk or negedge rstS_n) begin
      if (!rstS_n) begin
         state     <= ST_IDLE;
         waitData  <= 1'b0;
         memAddr   <= 16'h0000;
         memSpaceY <= 1'b0;
         memRead   <= 1'b0;
         memWrite  <= 1'b0;
         memWrData <= 24'h000000;
         posWord   <= 24'h000000;
         fbRaw[0]  <= 24'h000000;
         fbRaw[1]  <= 24'h000000;
         wrData[0] <= 24'h000000;
         wrData[1] <= 24'h000000;
         wrData[2] <= 24'h000000;
         wrIdx     <= 2'h0;
         wrTotal   <= 2'h0;
      end else begin
         memRead  <= 1'b0;
         memWrite <= 1'b0;
         case (state)
            ST_IDLE: begin
               wrIdx <= 2'h0;
               if (phaseTick && commEnable) begin
                  // Ongoing position, phase-advance register when microstepping
                  memAddr   <= posAddr[15:0];
                  memSpaceY <= posAddr[`POS_SPACE_BIT];
                  memRead   <= 1'b1;
                  state     <= ST_POS;
               end else if (phaseTick) begin
                  // No commutation: single torque command
                  wrData[0] <= torqueCmd;
                  wrTotal   <= 2'h1;
                  state     <= ST_WR;
               end
            end
            ST_POS: begin
               if (!waitData) begin
                  waitData <= 1'b1;
               end else begin
                  waitData <= 1'b0;
                  posWord  <= memRdData;
                  if (loopOn && !localHit) begin
                     memAddr   <= fbAddr[15:0];
                     memSpaceY <= 1'b1;
                     memRead   <= 1'b1;
                     state     <= ST_FBA;
                  end else begin
                     if (loopOn) begin
                        fbRaw[0] <= adcWord[0];
                        fbRaw[1] <= adcWord[1];
                     end
                     state <= ST_CALC;
                  end
               end
            end
            ST_FBA: begin
               if (!waitData) begin
                  waitData <= 1'b1;
               end else begin
                  waitData  <= 1'b0;
                  fbRaw[0]  <= memRdData;
                  memAddr   <= fbAddr[15:0] - 16'h0001;
                  memRead   <= 1'b1;
                  state     <= ST_FBB;
               end
            end
            ST_FBB: begin
               if (!waitData) begin
                  waitData <= 1'b1;
               end else begin
                  waitData <= 1'b0;
                  fbRaw[1] <= memRdData;
                  state    <= ST_CALC;
               end
            end
            ST_CALC: begin
               if (loopOn) begin
                  wrData[0] <= vOut[0];
                  wrData[1] <= vOut[1];
                  wrData[2] <= vThird;
                  wrTotal   <= 2'h3;
               end else begin
                  // Commutating without loop: two phase-current commands
                  wrData[0] <= cmdPh[0];
                  wrData[1] <= cmdPh[1];
                  wrTotal   <= 2'h2;
               end
               state <= ST_WR;
            end
            ST_WR: begin
               memWrite  <= 1'b1;
               memSpaceY <= 1'b1;
               memAddr   <= cmdOutAddr[15:0] + {14'h0000, wrIdx};
               memWrData <= wrData[wrIdx];
               wrIdx     <= wrIdx + 2'h1;
               if (wrIdx == wrTotal - 2'h1) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // AXI write channel: address and data in either order
   always @(posedge mclk or negedge rstS_n) begin
      if (!rstS_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
         awHave        <= 1'b0;
         wHave         <= 1'b0;
         awAddrHold    <= 8'h00;
         wDataHold     <= 32'h00000000;
         fbAddr        <= `RST_FB_ADDR;
         posAddr       <= POS_RESET;
         fbMask        <= `RST_FB_MASK;
         commEnable    <= 1'b0;
         cmdOutAddr    <= `RST_ZERO;
         kiGain        <= `RST_ZERO;
         kpFwd         <= `RST_ZERO;
         kpBack        <= `RST_ZERO;
         pwmScale      <= `RST_ZERO;
         phaseAngle    <= `RST_ZERO;
         torqueCmd     <= `RST_ZERO;
      end else begin
         s_axi_awready <= !awHave && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= !wHave && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            awHave     <= 1'b1;
            awAddrHold <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHave     <= 1'b1;
            wDataHold <= s_axi_wdata;
            s_axi_wready <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (awHave && wHave && !s_axi_bvalid) begin
            awHave       <= 1'b0;
            wHave        <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `RESP_OKAY;
            // Whole-word update regardless of s_axi_wstrb
            case (awAddrHold)
               `OFS_FB_ADDR:     fbAddr     <= wDataHold[23:0];
               `OFS_POS_ADDR:    posAddr    <= wDataHold[23:0];
               `OFS_FB_MASK:     fbMask     <= wDataHold[23:0];
               `OFS_COMM_EN:     commEnable <= wDataHold[0];
               `OFS_CMD_OUT:     cmdOutAddr <= wDataHold[23:0];
               `OFS_KI:          kiGain     <= wDataHold[23:0];
               `OFS_KP_FWD:      kpFwd      <= wDataHold[23:0];
               `OFS_KP_BACK:     kpBack     <= wDataHold[23:0];
               `OFS_PWM_SCALE:   pwmScale   <= wDataHold[23:0];
               `OFS_PHASE_ANGLE: phaseAngle <= wDataHold[23:0];
               `OFS_TORQUE_CMD:  torqueCmd  <= wDataHold[23:0];
               `OFS_POS_VALUE,
               `OFS_STATUS:      s_axi_bresp <= `RESP_OKAY;
               default:          s_axi_bresp <= `RESP_SLVERR;
            endcase
         end
      end
   end

   // AXI read channel
   always @(posedge mclk or negedge rstS_n) begin
      if (!rstS_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `RESP_OKAY;
            case (s_axi_araddr)
               `OFS_FB_ADDR:     s_axi_rdata <= {8'h00, fbAddr};
               `OFS_POS_ADDR:    s_axi_rdata <= {8'h00, posAddr};
               `OFS_FB_MASK:     s_axi_rdata <= {8'h00, fbMask};
               `OFS_COMM_EN:     s_axi_rdata <= {31'h00000000, commEnable};
               `OFS_CMD_OUT:     s_axi_rdata <= {8'h00, cmdOutAddr};
               `OFS_KI:          s_axi_rdata <= {8'h00, kiGain};
               `OFS_KP_FWD:      s_axi_rdata <= {8'h00, kpFwd};
               `OFS_KP_BACK:     s_axi_rdata <= {8'h00, kpBack};
               `OFS_PWM_SCALE:   s_axi_rdata <= {8'h00, pwmScale};
               `OFS_PHASE_ANGLE: s_axi_rdata <= {8'h00, phaseAngle};
               `OFS_TORQUE_CMD:  s_axi_rdata <= {8'h00, torqueCmd};
               `OFS_POS_VALUE:   s_axi_rdata <= {8'h00, posWord};
               `OFS_STATUS:      s_axi_rdata <= {24'h000000, localHit, loopOn, state};
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `RESP_SLVERR;
               end
            endcase
         end
      end
   end
endmodule // current_loop_feedback_select

// ===== rtl/current_loop_regs.vh
// Register offsets, reset values and fixed addresses of the current-loop feedback block.
// Assumes a 32-bit AXI4-Lite slave with byte addresses and one register per aligned word.
`ifndef CURRENT_LOOP_REGS_VH
`define CURRENT_LOOP_REGS_VH

// Register byte offsets
`define OFS_FB_ADDR      8'h00
`define OFS_POS_ADDR     8'h04
`define OFS_FB_MASK      8'h08
`define OFS_COMM_EN      8'h0C
`define OFS_CMD_OUT      8'h10
`define OFS_KI           8'h14
`define OFS_KP_FWD       8'h18
`define OFS_KP_BACK      8'h1C
`define OFS_PWM_SCALE    8'h20
`define OFS_PHASE_ANGLE  8'h24
`define OFS_TORQUE_CMD   8'h28
`define OFS_POS_VALUE    8'h2C
`define OFS_STATUS       8'h30

// Reset values
`define RST_FB_ADDR      24'h000000
`define RST_FB_MASK      24'hFFF000
`define RST_POS_ADDR     24'h00C001
`define RST_POS_RING     24'h08C0A0
`define RST_ZERO         24'h000000

// Field positions
`define POS_SPACE_BIT    19
`define CMD_MICROSTEP    16

// Directly connected ADC pair addresses
`define ADC_PAIR_BASE    16'hC006
`define ADC_PAIR_STEP    16'h0008

// ADC framing
`define ADC_SHIFT_BITS   18
`define ADC_WORD_BITS    24

// Phase interrupt period in mclk cycles
`define PHASE_DIV        12'hFA0

// AXI responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ===== verif/current_loop_asserts.sv
// Checker for AXI4-Lite handshakes, the command-write burst and the phase interrupt spacing.
// Assumes it is bound onto the top module and sees only that module's ports.
`timescale 1ns/1ps
module current_loop_asserts #(
   parameter [11:0] PHASE_DIV = 12'hFA0  // Cycles per phase interrupt
) (
   input wire logic        mclk, rst_n, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
   input wire logic        s_axi_rready, s_axi_bvalid, s_axi_bready, s_axi_awready,
   input wire logic        s_axi_wready, memRead, memWrite, memSpaceY, phaseTick,
   input wire logic [15:0] memAddr
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   logic [11:0] cnt;   // Cycles since the last tick
   logic        seen;  // First tick has been seen
   // Counts the gap between phase ticks
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt  <= 12'h0;
         seen <= 1'b0;
      end else begin
         cnt  <= phaseTick ? 12'h1 : cnt + 12'h1;
         seen <= seen | phaseTick;
      end
   end
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_cmd_next;
      memWrite && $past(memWrite);
   endsequence
   a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
      else $error("read answer not one cycle after address");
   a_read_clear: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer not released");
   a_write_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer not released");
   a_ready_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("ready offered while answer pending");
   a_read_pulse: assert property (memRead |=> !memRead)
      else $error("memory read longer than one cycle");
   a_cmd_space: assert property (memWrite |-> memSpaceY)
      else $error("command write outside Y space");
   a_cmd_burst: assert property (s_cmd_next |-> memAddr == $past(memAddr) + 16'h1)
      else $error("command writes not at consecutive addresses");
   a_tick_period: assert property (seen |-> phaseTick == (cnt == PHASE_DIV))
      else $error("phase tick spacing wrong");
endmodule // current_loop_asserts

// ===== verif/current_loop_feedback_select_tb.sv
// Testbench: configures over AXI4-Lite, checks memory accesses of three phase sequences per run.
// Assumes the far-side model answers memory reads and holds the ADC clock and frame low.
`timescale 1ns/1ps
module current_loop_feedback_select_tb;
   localparam [11:0] PHASE_DIV = 12'h014;  // Short phase interrupt
   logic mclk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, comm, ign, act;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic adcSclk, adcFrame, adcDataA, adcDataB, memSpaceY, memRead, memWrite, phaseTick;
   logic [15:0] memAddr;
   logic [23:0] memWrData, memRdData, fb, pos, cmd, trq, msk, xd[3];
   logic [42:0] e, mq[$];  // Expected access: {checkData, write, spaceY, addr, data}
   logic [33:0] rq[$];     // Expected read answer: {resp, data}
   logic [1:0]  bq[$];     // Expected write response
   int error_cnt, n_tests, i, k;
   current_loop_feedback_select #(.PHASE_DIV(PHASE_DIV)) i_current_loop_feedback_select (.*);
   mem_adc_model i_mem_adc_model (.*);
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task stop_test;
      if (error_cnt == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [42:0] got, input logic [42:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task tmo(input int n);
      if (n >= 60) begin
         error_cnt++;
         stop_test;
      end
   endtask
   task wr(input logic [7:0] a, input logic [23:0] d);
      bq.push_back((a > 8'h30) ? 2'h2 : 2'h0);
      s_axi_awaddr <= a;
      s_axi_wdata <= {8'h00, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      for (i = 0; i < 60; i++) begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      tmo(i);
      s_axi_bready <= 1'b0;
      @(posedge mclk);
   endtask
   task rd(input logic [7:0] a, input logic [33:0] x);
      rq.push_back(x);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      for (i = 0; i < 60; i++) begin
         @(posedge mclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      tmo(i);
      s_axi_rready <= 1'b0;
      @(posedge mclk);
   endtask
   task wt;
      for (i = 0; i < 60; i++) begin
         @(posedge mclk);
         if (phaseTick) break;
      end
      tmo(i);
   endtask
   // Configure, then check the accesses of three whole phase sequences
   task run(input logic c, input logic sp, input logic [23:0] f, input logic [23:0] m);
      ign <= 1'b1;
      comm = c;
      fb = f;
      msk = m;
      pos = ($urandom & 24'h00FFFF) | {4'h0, sp, 19'h0};
      cmd = $urandom & 24'h00FFF0;
      trq = $urandom & 24'hFFFFFF;
      wr(8'h0C, {23'h0, c});
      wr(8'h00, f);
      wr(8'h04, pos);
      wr(8'h08, m);
      wr(8'h10, cmd);
      wr(8'h28, trq);
      mq.delete();
      wt;
      ign <= 1'b0;
      repeat (3) wt;
      ign <= 1'b1;
      wt;
      chk(43'(mq.size()), 43'h0);
   endtask
   // Notes the accesses that each phase tick must cause
   always @(posedge mclk) if (phaseTick) begin
      act <= !ign;
      if (!ign && !comm) mq.push_back({3'h7, cmd[15:0], trq});
      if (!ign && comm) begin
         mq.push_back({2'h0, pos[19], pos[15:0], 24'h0});
         // Square-wave phase commands from the position word read back
         xd[0] = pos[15] ? -trq : trq;
         xd[1] = (pos[15] ^ pos[14]) ? -trq : trq;
         if (fb != 24'h0 && fb[15:0] != 16'hC006) begin
            mq.push_back({3'h1, fb[15:0], 24'h0});
            mq.push_back({3'h1, fb[15:0] - 16'h1, 24'h0});
            // Back gain and scale of one half each: minus a quarter of the masked word
            xd[0] = -(({fb[15:0], 8'h5A} & msk) >> 2);
            xd[1] = -(({fb[15:0] - 16'h1, 8'h5A} & msk) >> 2);
         end else if (fb != 24'h0) begin
            xd[0] = 24'h0;
            xd[1] = 24'h0;
         end
         xd[2] = -(xd[0] + xd[1]);
         for (k = 0; k < (fb != 24'h0 ? 3 : 2); k++)
            mq.push_back({1'b1, 2'h3, cmd[15:0] + 16'(k), xd[k]});
      end
   end
   // Compares each access and read answer with the oldest note
   always @(posedge mclk) begin
      if (act && (memRead || memWrite)) begin
         e = (mq.size() > 0) ? mq.pop_front() : 43'h7FFFFFFFFFF;
         chk(43'({memWrite, memSpaceY, memAddr}), 43'(e[41:24]));
         if (e[42]) chk(43'(memWrData), 43'(e[23:0]));
      end
      if (s_axi_rvalid && s_axi_rready)
         chk(43'({s_axi_rresp, s_axi_rdata}), 43'(rq.pop_front()));
      if (s_axi_bvalid && s_axi_bready) chk(43'(s_axi_bresp), 43'(bq.pop_front()));
   end
   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_arvalid, s_axi_rready, act, error_cnt, n_tests} = '0;
      s_axi_wstrb = 4'hF;
      ign = 1'b1;
      rst_n = 1'b0;
      i = $urandom(3);
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      rd(8'h00, 34'h0);
      rd(8'h04, 34'h00C001);
      rd(8'h08, 34'hFFF000);
      rd(8'h40, 34'h200000000);
      wr(8'h1C, 24'h400000);
      wr(8'h20, 24'h400000);
      run(1'b0, 1'b0, 24'h0, 24'hFFF000);
      run(1'b0, 1'b0, 24'h000123, 24'hFFF000);
      run(1'b1, 1'b0, 24'h0, 24'hFFF000);
      run(1'b1, 1'b1, 24'h0, 24'hFFF000);
      run(1'b1, 1'b1, 24'h000123, 24'hFFC000);
      run(1'b1, 1'b0, 24'h00C006, 24'hFFFF00);
      wr(8'h44, 24'hFFFFFF);
      rd(8'h08, 34'hFFFF00);
      stop_test;
   end
endmodule // current_loop_feedback_select_tb
bind current_loop_feedback_select current_loop_asserts #(.PHASE_DIV(PHASE_DIV))
   i_current_loop_asserts (.*);

// ===== verif/mem_adc_model.sv
// Far-side model: controller memory answering reads, serial ADC clock and frame held low.
// Assumes read data is wanted on the cycle after memRead.
`timescale 1ns/1ps
module mem_adc_model (
   input wire logic        mclk,
   input wire logic        memRead,
   input wire logic [15:0] memAddr,
   output logic     [23:0] memRdData,
   output logic            adcSclk, adcFrame, adcDataA, adcDataB
);
   assign adcSclk  = 1'b0;  // No frames: serial clock stands still
   assign adcFrame = 1'b0;
   initial begin
      memRdData = 24'h0;
      adcDataA  = 1'b0;
      adcDataB  = 1'b1;
   end
   // Read answers carry amplifier status in the low byte; stale data is inverted
   always @(posedge mclk) begin
      memRdData <= memRead ? {memAddr, 8'h5A} : ~memRdData;
      adcDataA  <= ~adcDataA;
      adcDataB  <= ~adcDataB;
   end
endmodule // mem_adc_model
